// ==== core/hub_change_pkg.sv ====
// Constants shared by the port change tracker and the translator state reader
package hub_change_pkg;

  // ****************************************************************
  // Request encodings
  // ****************************************************************
  localparam logic [7:0]  REQ_TYPE_PORT_OUT   = 8'h23;  // Class, host to device, other
  localparam logic [7:0]  REQ_TYPE_TT_IN      = 8'hA3;  // Class, device to host, other
  localparam logic [7:0]  REQ_CLEAR_FEATURE   = 8'h01;
  localparam logic [7:0]  REQ_SET_FEATURE     = 8'h03;
  localparam logic [7:0]  REQ_GET_TT_STATE    = 8'h0A;

  // Feature selectors naming the change flags
  localparam logic [15:0] SEL_CHG_CONNECTION  = 16'h0010;
  localparam logic [15:0] SEL_CHG_ENABLE      = 16'h0011;
  localparam logic [15:0] SEL_CHG_SUSPEND     = 16'h0012;
  localparam logic [15:0] SEL_CHG_OVERCURRENT = 16'h0013;
  localparam logic [15:0] SEL_CHG_RESET       = 16'h0014;

  // ****************************************************************
  // Change word layout
  // ****************************************************************
  localparam int          CHG_CONN_BIT        = 0;
  localparam int          CHG_ENABLE_BIT      = 1;
  localparam int          CHG_SUSPEND_BIT     = 2;
  localparam int          CHG_OC_BIT          = 3;
  localparam int          CHG_RESET_BIT       = 4;
  localparam int          CHG_USED_BITS       = 5;
  localparam logic [4:0]  CHG_FLAGS_RESET     = 5'h00;
  localparam logic [10:0] CHG_RESERVED_VALUE  = 11'h000;

  // ****************************************************************
  // Returned translator state layout
  // ****************************************************************
  localparam logic [15:0] TT_FLAGS_BYTES      = 16'h0004;
  localparam logic [15:0] TT_RETURN_LOW_VALUE = 16'h0000;

endpackage : hub_change_pkg

// ==== core/tt_state_reader.sv ====
// Serialiser for the translator state returned in a readback data stage
`timescale 1ns/10ps
`default_nettype none

module tt_state_reader
  import hub_change_pkg::*;
#(
  parameter logic [15:0] STATE_BYTES = 16'h0010
)(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  // Control
  input  wire logic        start_i,
  input  wire logic [15:0] length_i,
  input  wire logic [15:0] vendor_flags_i,
  output logic             busy_o,
  output logic             done_o,
  // Translator state source
  output logic [15:0]      state_addr_o,
  input  wire logic [7:0]  state_byte_i,
  // Byte stream
  output logic [7:0]       data_o,
  output logic             data_valid_o,
  output logic             data_last_o,
  input  wire logic        data_ready_i
);

  typedef enum logic [1:0] {RD_IDLE, RD_LOAD, RD_SEND} rd_state_e;

  localparam logic [15:0] TOTAL_BYTES = TT_FLAGS_BYTES + STATE_BYTES;

  rd_state_e   state;
  logic [15:0] pos;
  logic [15:0] total;
  logic [15:0] vflags;

  // Byte at a position: return flags little endian, low half zero
  function automatic logic [7:0] byte_at(input logic [15:0] p, input logic [15:0] vf,
                                         input logic [7:0] sb);
    case (p)
      16'h0000: byte_at = TT_RETURN_LOW_VALUE[7:0];
      16'h0001: byte_at = TT_RETURN_LOW_VALUE[15:8];
      16'h0002: byte_at = vf[7:0];
      16'h0003: byte_at = vf[15:8];
      default:  byte_at = sb;
    endcase
  endfunction : byte_at

  // Implementation bytes start after the flags word
  assign state_addr_o = pos - TT_FLAGS_BYTES;
  assign busy_o       = (state != RD_IDLE);

  // Sequencer; a one-cycle gap per byte keeps the data path a plain flop
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      state        <= RD_IDLE;
      pos          <= 16'h0000;
      total        <= 16'h0000;
      vflags       <= 16'h0000;
      data_o       <= 8'h00;
      data_valid_o <= 1'b0;
      data_last_o  <= 1'b0;
      done_o       <= 1'b0;
    end
    else
    begin
      done_o <= 1'b0;
      case (state)
        RD_IDLE:
        begin
          if (start_i)
          begin
            pos    <= 16'h0000;
            vflags <= vendor_flags_i;
            // Short length truncates, long length is cut to the real size
            total  <= (length_i > TOTAL_BYTES) ? TOTAL_BYTES : length_i;
            if (length_i == 16'h0000)
              done_o <= 1'b1;  // Zero length is a clean finish
            else
              state <= RD_LOAD;
          end
        end
        RD_LOAD:
        begin
          data_o       <= byte_at(pos, vflags, state_byte_i);
          data_valid_o <= 1'b1;
          data_last_o  <= (pos == total - 16'h0001);
          pos          <= pos + 16'h0001;
          state        <= RD_SEND;
        end
        RD_SEND:
        begin
          if (data_ready_i)
          begin
            data_valid_o <= 1'b0;
            data_last_o  <= 1'b0;
            if (data_last_o)
            begin
              done_o <= 1'b1;
              state  <= RD_IDLE;
            end
            else
              state <= RD_LOAD;
          end
        end
        default:
          state <= RD_IDLE;
      endcase
    end
  end

endmodule : tt_state_reader

`default_nettype wire

// ==== core/hub_port_change_and_tt_state.sv ====
// Port change flag register and translator state readback for one hub port
`timescale 1ns/10ps
`default_nettype none

module hub_port_change_and_tt_state
  import hub_change_pkg::*;
#(
  parameter logic [7:0]  PORT_NUM      = 8'h01,   // This port's number
  parameter logic [7:0]  NUM_PORTS     = 8'h04,   // Ports on the hub
  parameter bit          PER_PORT_OC   = 1'b1,    // Per-port over-current reporting
  parameter bit          DIAG_SET_EN   = 1'b0,    // Allow setting change flags
  parameter bit          DIAG_SET_ERR  = 1'b1,    // Refuse unsupported sets with error
  parameter bit          INV_IDLE_EN   = 1'b1,    // Flag reset left disabled
  parameter logic [15:0] TT_STATE_BYTES = 16'h0010
)(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  // Decoded control request
  input  wire logic        req_valid_i,
  output logic             req_ready_o,
  input  wire logic [7:0]  req_type_i,
  input  wire logic [7:0]  req_code_i,
  input  wire logic [15:0] req_value_i,
  input  wire logic [15:0] req_index_i,
  input  wire logic [15:0] req_length_i,
  output logic             req_done_o,
  output logic             req_error_o,
  // Port state machine observations
  input  wire logic        attach_detach_i,
  input  wire logic        port_error_disable_i,
  input  wire logic        reset_invalid_idle_i,
  input  wire logic        resume_to_sendeop_i,
  input  wire logic        restart_to_transmit_i,
  input  wire logic        reset_to_enabled_i,
  input  wire logic        over_current_i,
  input  wire logic        other_oc_power_off_i,
  input  wire logic        powered_off_i,
  input  wire logic        not_configured_i,
  // Change word
  output logic [15:0]      port_change_flags_o,
  // Translator state source
  input  wire logic [15:0] tt_vendor_flags_i,
  output logic [15:0]      tt_state_addr_o,
  input  wire logic [7:0]  tt_state_byte_i,
  // Readback data stage
  output logic [7:0]       tt_data_o,
  output logic             tt_data_valid_o,
  output logic             tt_data_last_o,
  input  wire logic        tt_data_ready_i
);

  // ****************************************************************
  // Request decode
  // ****************************************************************

  logic       req_take;
  logic       port_req;
  logic       is_clear;
  logic       is_set;
  logic       is_tt_get;
  logic       tt_bad_port;
  logic [4:0] sel_hit;
  logic [4:0] clr_req;
  logic [4:0] set_req;
  logic       tt_busy;
  logic       tt_done;

  // Requests wait while a readback streams or finishes, so no answer is lost
  assign req_ready_o = !tt_busy && !tt_done;
  assign req_take    = req_valid_i && req_ready_o;
  assign port_req    = (req_type_i == REQ_TYPE_PORT_OUT) && (req_index_i[7:0] == PORT_NUM);
  assign is_clear    = port_req && (req_code_i == REQ_CLEAR_FEATURE);
  assign is_set      = port_req && (req_code_i == REQ_SET_FEATURE);
  assign is_tt_get   = (req_type_i == REQ_TYPE_TT_IN) && (req_code_i == REQ_GET_TT_STATE);
  // Port zero, ports past the last, or a high index byte name no port
  assign tt_bad_port = (req_index_i[7:0] == 8'h00) || (req_index_i[7:0] > NUM_PORTS)
                       || (req_index_i[15:8] != 8'h00);

  // Selector to flag one-hot
  assign sel_hit[CHG_CONN_BIT]    = (req_value_i == SEL_CHG_CONNECTION);
  assign sel_hit[CHG_ENABLE_BIT]  = (req_value_i == SEL_CHG_ENABLE);
  assign sel_hit[CHG_SUSPEND_BIT] = (req_value_i == SEL_CHG_SUSPEND);
  assign sel_hit[CHG_OC_BIT]      = (req_value_i == SEL_CHG_OVERCURRENT);
  assign sel_hit[CHG_RESET_BIT]   = (req_value_i == SEL_CHG_RESET);

  assign clr_req = (req_take && is_clear) ? sel_hit : 5'h00;
  assign set_req = (req_take && is_set && DIAG_SET_EN) ? sel_hit : 5'h00;

  // ****************************************************************
  // Change flags
  // ****************************************************************

  logic [4:0] flags;
  logic       oc_prev;
  logic [4:0] hw_set;

  // Flag update; a level hold wins, then a hardware set beats a request clear
  function automatic logic next_flag(input logic cur, input logic set, input logic clr,
                                     input logic hold);
    if (hold)
      next_flag = 1'b0;
    else if (set)
      next_flag = 1'b1;
    else if (clr)
      next_flag = 1'b0;
    else
      next_flag = cur;  // Latched regardless of status
  endfunction : next_flag

  // Hardware set events, with optional diagnostic sets folded in
  always_comb
  begin
    hw_set                  = set_req;
    hw_set[CHG_CONN_BIT]    = hw_set[CHG_CONN_BIT] | attach_detach_i;
    // An error-driven disable counts, and with INV_IDLE_EN so does a reset left disabled
    hw_set[CHG_ENABLE_BIT]  = hw_set[CHG_ENABLE_BIT] | port_error_disable_i
                              | (INV_IDLE_EN && reset_invalid_idle_i);
    hw_set[CHG_SUSPEND_BIT] = hw_set[CHG_SUSPEND_BIT] | resume_to_sendeop_i
                              | restart_to_transmit_i;
    hw_set[CHG_OC_BIT]      = hw_set[CHG_OC_BIT] | (over_current_i != oc_prev)
                              | other_oc_power_off_i;
    hw_set[CHG_RESET_BIT]   = hw_set[CHG_RESET_BIT] | reset_to_enabled_i;
  end

  // Previous over-current level for edge detection
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      oc_prev <= 1'b0;
    else
      oc_prev <= over_current_i;
  end

  // Flag register; hub reset clears everything
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      flags <= CHG_FLAGS_RESET;
    else
    begin
      flags[CHG_CONN_BIT]    <= next_flag(flags[CHG_CONN_BIT], hw_set[CHG_CONN_BIT],
                                          clr_req[CHG_CONN_BIT], powered_off_i);
      flags[CHG_ENABLE_BIT]  <= next_flag(flags[CHG_ENABLE_BIT], hw_set[CHG_ENABLE_BIT],
                                          clr_req[CHG_ENABLE_BIT], powered_off_i);
      flags[CHG_SUSPEND_BIT] <= next_flag(flags[CHG_SUSPEND_BIT], hw_set[CHG_SUSPEND_BIT],
                                          clr_req[CHG_SUSPEND_BIT], powered_off_i);
      // Shared over-current reporting pins the flag low
      flags[CHG_OC_BIT]      <= next_flag(flags[CHG_OC_BIT], hw_set[CHG_OC_BIT],
                                          clr_req[CHG_OC_BIT],
                                          not_configured_i || !PER_PORT_OC);
      flags[CHG_RESET_BIT]   <= next_flag(flags[CHG_RESET_BIT], hw_set[CHG_RESET_BIT],
                                          clr_req[CHG_RESET_BIT], powered_off_i);
    end
  end

  // Reserved upper bits are constant zero
  assign port_change_flags_o = {CHG_RESERVED_VALUE, flags};

  // ****************************************************************
  // Request answers
  // ****************************************************************

  // Feature requests and refused readbacks answer next cycle; readback answers when streaming ends
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      req_done_o  <= 1'b0;
      req_error_o <= 1'b0;
    end
    else
    begin
      req_done_o  <= 1'b0;
      req_error_o <= 1'b0;
      if (tt_done)
        req_done_o <= 1'b1;
      else if (req_take && (is_clear || is_set) && (sel_hit != 5'h00))
      begin
        // Unsupported diagnostic set: error, or done with no effect
        if (is_set && !DIAG_SET_EN && DIAG_SET_ERR)
          req_error_o <= 1'b1;
        else
          req_done_o <= 1'b1;
      end
      else if (req_take && is_tt_get && tt_bad_port)
        req_error_o <= 1'b1;
    end
  end

  // ****************************************************************
  // Translator state readback
  // ****************************************************************

  // Value is unused, flags come from tt_vendor_flags_i, index the port, length the byte budget
  tt_state_reader #(
    .STATE_BYTES    (TT_STATE_BYTES)
  ) u_reader (
    .clk_i          (clk_i),
    .arst_n_i       (arst_n_i),
    .start_i        (req_take && is_tt_get && !tt_bad_port),
    .length_i       (req_length_i),
    .vendor_flags_i (tt_vendor_flags_i),
    .busy_o         (tt_busy),
    .done_o         (tt_done),
    .state_addr_o   (tt_state_addr_o),
    .state_byte_i   (tt_state_byte_i),
    .data_o         (tt_data_o),
    .data_valid_o   (tt_data_valid_o),
    .data_last_o    (tt_data_last_o),
    .data_ready_i   (tt_data_ready_i)
  );

  // ****************************************************************
  // Assertions
  // ****************************************************************

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  logic [15:0] sent_bytes;
  logic [15:0] req_len_q;

  // Byte counter for the current readback, used by the length and low-flags checks
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      sent_bytes <= 16'h0000;
      req_len_q  <= 16'h0000;
    end
    else if (req_take && is_tt_get)
    begin
      sent_bytes <= 16'h0000;
      req_len_q  <= req_length_i;
    end
    else if (tt_data_valid_o && tt_data_ready_i)
      sent_bytes <= sent_bytes + 16'h0001;
  end

  clear_clears_a: assert property (
    clr_req[CHG_CONN_BIT] && !attach_detach_i && !set_req[CHG_CONN_BIT]
    |=> !port_change_flags_o[CHG_CONN_BIT])
    else $error("connect change not cleared by request");

  conn_set_a: assert property (
    attach_detach_i && !powered_off_i |=> port_change_flags_o[CHG_CONN_BIT])
    else $error("connect change not set on attach or detach");

  powered_off_hold_a: assert property (
    powered_off_i |=> (port_change_flags_o[CHG_SUSPEND_BIT] == 1'b0)
                      && (port_change_flags_o[CHG_RESET_BIT] == 1'b0))
    else $error("suspend or reset change set while powered off");

  enable_cause_a: assert property (
    $rose(port_change_flags_o[CHG_ENABLE_BIT])
    |-> $past(port_error_disable_i || reset_invalid_idle_i || set_req[CHG_ENABLE_BIT]))
    else $error("enable change set without a port error");

  oc_edge_a: assert property (
    PER_PORT_OC && !not_configured_i && $changed(over_current_i)
    |=> port_change_flags_o[CHG_OC_BIT])
    else $error("over-current change missed a status edge");

  oc_unconf_a: assert property (
    not_configured_i |=> !port_change_flags_o[CHG_OC_BIT])
    else $error("over-current change set while not configured");

  reserved_zero_a: assert property (
    port_change_flags_o[15:5] == 11'h000)
    else $error("reserved change bits not zero");

  flag_latched_a: assert property (
    port_change_flags_o[CHG_SUSPEND_BIT] && !powered_off_i && !clr_req[CHG_SUSPEND_BIT]
    |=> port_change_flags_o[CHG_SUSPEND_BIT])
    else $error("suspend change dropped without a clear");

  bad_port_err_a: assert property (
    req_take && is_tt_get && tt_bad_port |=> req_error_o && !tt_busy)
    else $error("readback of missing port not refused");

  length_cap_a: assert property (
    tt_data_valid_o |-> sent_bytes < req_len_q
                        && sent_bytes < TT_FLAGS_BYTES + TT_STATE_BYTES)
    else $error("readback exceeds requested or real length");

  zero_len_a: assert property (
    req_take && is_tt_get && !tt_bad_port && (req_length_i == 16'h0000)
    |=> ##1 req_done_o && !tt_data_valid_o)
    else $error("zero length readback not finished cleanly");

  flags_first_a: assert property (
    tt_data_valid_o && (sent_bytes < 16'h0002) |-> tt_data_o == 8'h00)
    else $error("low return flags not zero");

  cov_conn_clear_c: cover property (
    port_change_flags_o[CHG_CONN_BIT] ##[1:20] !port_change_flags_o[CHG_CONN_BIT]);
  cov_tt_full_c: cover property (tt_data_valid_o && tt_data_last_o && tt_data_ready_i);
  cov_tt_err_c: cover property (req_error_o);
  cov_set_wins_c: cover property (clr_req[CHG_RESET_BIT] && reset_to_enabled_i);

endmodule : hub_port_change_and_tt_state

`default_nettype wire

// ==== testbench/tt_far_side.sv ====
// Host-side model: translator state source and stalling data sink
`timescale 1ns/10ps
`default_nettype none

module tt_far_side (
  // Clock
  input  wire logic        clk_i,
  // State source
  input  wire logic [15:0] addr_i,
  output logic [7:0]       byte_o,
  // Data stage sink
  output logic             ready_o
);
  logic [1:0] cnt = 2'h0;

  // State bytes follow the address so each position is recognisable
  assign byte_o = addr_i[7:0] + 8'h30;

  // Stall one cycle in three so the stream must hold its byte
  always @(posedge clk_i)
    cnt <= #1 (cnt == 2'h2) ? 2'h0 : cnt + 2'h1;
  assign ready_o = (cnt != 2'h0);
endmodule : tt_far_side
`default_nettype wire

// ==== testbench/testbench.sv ====
// Self-checking bench for the port change word and translator readback
`timescale 1ns/10ps
`default_nettype none

module testbench
  import hub_change_pkg::*;
;
  localparam logic [15:0] VEND = 16'hC3A5;
  logic clk_i, arst_n_i, req_valid_i, req_ready_o, req_done_o, req_error_o;
  logic [7:0] req_type_i, req_code_i, tt_state_byte_i, tt_data_o;
  logic [15:0] req_value_i, req_index_i, req_length_i, flags, tt_state_addr_o;
  logic [6:0] ev;
  logic over_current_i, powered_off_i, not_configured_i;
  logic tt_data_valid_o, tt_data_last_o, tt_data_ready_i;
  logic [1:0] ans;
  logic [8:0] rx[$];
  int n_errors, n_compared, evbit[7], tt[7][4];

  hub_port_change_and_tt_state DUT (.clk_i(clk_i), .arst_n_i(arst_n_i),
    .req_valid_i(req_valid_i), .req_ready_o(req_ready_o), .req_type_i(req_type_i),
    .req_code_i(req_code_i), .req_value_i(req_value_i), .req_index_i(req_index_i),
    .req_length_i(req_length_i), .req_done_o(req_done_o), .req_error_o(req_error_o),
    .attach_detach_i(ev[0]), .port_error_disable_i(ev[1]), .reset_invalid_idle_i(ev[2]),
    .resume_to_sendeop_i(ev[3]), .restart_to_transmit_i(ev[4]),
    .reset_to_enabled_i(ev[5]), .over_current_i(over_current_i),
    .other_oc_power_off_i(ev[6]), .powered_off_i(powered_off_i),
    .not_configured_i(not_configured_i), .port_change_flags_o(flags),
    .tt_vendor_flags_i(VEND), .tt_state_addr_o(tt_state_addr_o),
    .tt_state_byte_i(tt_state_byte_i), .tt_data_o(tt_data_o),
    .tt_data_valid_o(tt_data_valid_o), .tt_data_last_o(tt_data_last_o),
    .tt_data_ready_i(tt_data_ready_i));

  tt_far_side host (.clk_i(clk_i), .addr_i(tt_state_addr_o), .byte_o(tt_state_byte_i),
    .ready_o(tt_data_ready_i));

  // ****************************************************************
  // Clock, byte monitor and helpers
  // ****************************************************************
  initial
  begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  // Collect every byte the sink accepts, with its last marker
  always @(negedge clk_i)
    if (tt_data_valid_o === 1'b1 && tt_data_ready_i === 1'b1)
      rx.push_back({tt_data_last_o, tt_data_o});

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // One request; ans is 1 for done, 2 for error, 0 for silence
  task automatic req(input logic [7:0] c, input logic [15:0] v, input logic [15:0] x,
                     input logic [15:0] l);
    int k;
    @(posedge clk_i);
    #1;
    ans = 2'h0;
    req_type_i = (c == REQ_GET_TT_STATE) ? REQ_TYPE_TT_IN : REQ_TYPE_PORT_OUT;
    {req_code_i, req_value_i, req_index_i, req_length_i} = {c, v, x, l};
    req_valid_i = 1'b1;
    k = 0;
    // Ready settles after the edge; the request is taken at the next one
    while (req_ready_o !== 1'b1 && k < 50)
    begin
      @(posedge clk_i);
      #1;
      k++;
    end
    if (k == 50) n_errors++;
    @(posedge clk_i);
    #1;
    req_valid_i = 1'b0;
    for (k = 0; k < 300 && ans == 2'h0; k++)
      if (req_done_o === 1'b1) ans = 2'h1;
      else if (req_error_o === 1'b1) ans = 2'h2;
      else
      begin
        @(posedge clk_i);
        #1;
      end
  endtask : req

  // One-cycle event pulse; its flag is visible when the task returns
  task automatic pulse(input int i);
    @(posedge clk_i);
    #1;
    ev[i] = 1'b1;
    @(posedge clk_i);
    #1;
    ev[i] = 1'b0;
  endtask : pulse

  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish

  // Watchdog far beyond the few hundred cycles the tests need
  initial
  begin
    #160000;
    n_errors++;
    tally_and_finish();
  end

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial
  begin
    {arst_n_i, req_valid_i, ev, over_current_i, powered_off_i, not_configured_i} = '0;
    {req_type_i, req_code_i, req_value_i, req_index_i, req_length_i} = '0;
    evbit = '{0, 1, 1, 2, 2, 4, 3};
    tt = '{'{1, 0, 1, 0}, '{1, 2, 1, 2}, '{2, 7, 1, 7}, '{4, 40, 1, 20},
           '{0, 8, 2, 0}, '{5, 8, 2, 0}, '{16'h0101, 8, 2, 0}};
    repeat (6) @(posedge clk_i);
    #1;
    arst_n_i = 1'b1;
    chk("flags after reset", 16'h0000, flags);
    // Each event latches its own bit until the matching clear
    for (int i = 0; i < 7; i++)
    begin
      pulse(i);
      repeat (3) @(posedge clk_i);
      #1;
      chk("event flag", 16'h1 << evbit[i], flags);
      req(REQ_CLEAR_FEATURE, SEL_CHG_CONNECTION + 16'(evbit[i]), 16'h0001, 16'h0000);
      chk("clear answer", 16'h1, 16'(ans));
      chk("flag cleared", 16'h0000, flags);
    end
    $display("test event flags done");
    req(REQ_SET_FEATURE, SEL_CHG_CONNECTION, 16'h0001, 16'h0000);
    chk("set answer", 16'h2, 16'(ans));
    chk("set no effect", 16'h0000, flags);
    // Event and clear in one cycle: the event wins
    fork
      req(REQ_CLEAR_FEATURE, SEL_CHG_RESET, 16'h0001, 16'h0000);
      pulse(5);
    join
    chk("set beats clear", 16'h0010, flags);
    req(REQ_CLEAR_FEATURE, SEL_CHG_RESET, 16'h0001, 16'h0000);
    chk("reset change cleared", 16'h0000, flags);
    // Both edges of over-current status count as changes
    over_current_i = 1'b1;
    repeat (3) @(posedge clk_i);
    #1;
    chk("oc rise", 16'h0008, flags);
    req(REQ_CLEAR_FEATURE, SEL_CHG_OVERCURRENT, 16'h0001, 16'h0000);
    chk("oc cleared", 16'h0000, flags);
    over_current_i = 1'b0;
    repeat (3) @(posedge clk_i);
    #1;
    chk("oc fall", 16'h0008, flags);
    $display("test over-current done");
    // Power-off holds every flag except over-current at zero
    foreach (evbit[i]) if (i != 6) pulse(i);
    chk("all flags", 16'h001F, flags);
    powered_off_i = 1'b1;
    pulse(0);
    pulse(3);
    @(posedge clk_i);
    #1;
    chk("powered off", 16'h0008, flags);
    powered_off_i = 1'b0;
    not_configured_i = 1'b1;
    pulse(6);
    @(posedge clk_i);
    #1;
    chk("not configured", 16'h0000, flags);
    not_configured_i = 1'b0;
    $display("test level holds done");
    // Readback: zero length, lengths below and above the real size, bad ports
    // Translator is taken as already stopped by the host
    for (int t = 0; t < 7; t++)
    begin
      rx.delete();
      req(REQ_GET_TT_STATE, 16'h5A00, 16'(tt[t][0]), 16'(tt[t][1]));
      chk("tt answer", 16'(tt[t][2]), 16'(ans));
      chk("tt count", 16'(tt[t][3]), 16'(rx.size()));
      foreach (rx[p])
        chk("tt byte", {7'h00, p == tt[t][3] - 1,
            p < 2 ? 8'h00 : p == 2 ? VEND[7:0] : p == 3 ? VEND[15:8] : 8'(p - 4 + 8'h30)},
            {7'h00, rx[p]});
    end
    $display("test readback done");
    pulse(0);
    chk("flag before hub reset", 16'h0001, flags);
    arst_n_i = 1'b0;
    repeat (2) @(posedge clk_i);
    #1;
    arst_n_i = 1'b1;
    chk("flags after hub reset", 16'h0000, flags);
    $display("test hub reset done");
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
